// File: verilog/cdar_consts.vh
// constants of the cable diagnostic amplitude and general result register bank
`ifndef CDAR_CONSTS_VH
`define CDAR_CONSTS_VH

// ----------------------------------------------------------------
// register bus geometry
// ----------------------------------------------------------------
`define CDAR_ADDR_W          16
`define CDAR_DATA_W          16
`define CDAR_DATA_ZERO       16'h0000

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CDAR_OFF_AMP3        16'h0187
`define CDAR_OFF_AMP4        16'h0188
`define CDAR_OFF_AMP5        16'h0189
`define CDAR_OFF_GEN         16'h018A
`define CDAR_OFF_IRQ_STAT    16'h01A0
`define CDAR_OFF_IRQ_MASK    16'h01A1
`define CDAR_OFF_INFO        16'h01A2

// ----------------------------------------------------------------
// amplitude field layout
// ----------------------------------------------------------------
`define CDAR_AMP_W           7
`define CDAR_PEAKS           5
`define CDAR_AMP_RST         7'h00

// ----------------------------------------------------------------
// general result field layout
// ----------------------------------------------------------------
`define CDAR_POL_RST         5'h00
`define CDAR_GEN_RSVD        2'h0

// ----------------------------------------------------------------
// interrupt status / mask layout
// ----------------------------------------------------------------
`define CDAR_IRQ_W           3
`define CDAR_IRQ_RST         3'h0
`define CDAR_IRQ_DONE        0
`define CDAR_IRQ_SHORT       1
`define CDAR_IRQ_OVFL        2
`define CDAR_IRQ_PAD_W       13
`define CDAR_INFO_PAD_W      14

`endif

// File: verilog/cdar_results.v
// cable diagnostic amplitude, polarity and cross-detect result register bank
//
// Contract
// - bits 15 and 7 of each amplitude register read zero, writes ignored.
// - results are meaningful only once the diagnostic done flag reads one.
// - 0x0187 bits 14:8 hold receive-pair first peak amplitude.
// - 0x0187 bits 6:0 hold transmit-pair fifth peak amplitude.
// - 0x0188 holds receive-pair third (14:8) and second (6:0) amplitudes.
// - 0x0189 holds receive-pair fifth (14:8) and fourth (6:0) amplitudes.
// - general bits 15..11 give transmit-pair peak polarity five down to one.
// - general bits 10..6 give receive-pair peak polarity five down to one.
// - general bit 5 flags transmit-pair cross reflection, a pair short.
// - general bit 4 flags receive-pair cross reflection, a pair short.
// - bits 3 and 2 flag above five reflections; bits 1:0 read zero.
`include "cdar_consts.vh"

module cdar_results (
  // clock and reset
  input  wire                        ref_clk,
  input  wire                        sys_rst,
  // register port
  input  wire [`CDAR_ADDR_W-1:0]     reg_addr,
  input  wire [`CDAR_DATA_W-1:0]     reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [`CDAR_DATA_W-1:0]     reg_rdata_ff,
  // reflectometry engine
  input  wire                        tdr_run_start,
  input  wire                        tdr_run_done,
  input  wire [`CDAR_AMP_W-1:0]      tdr_tx_amp5,
  input  wire [`CDAR_PEAKS*`CDAR_AMP_W-1:0] tdr_rx_amp,
  input  wire [`CDAR_PEAKS-1:0]      tdr_tx_pol,
  input  wire [`CDAR_PEAKS-1:0]      tdr_rx_pol,
  input  wire                        tdr_tx_cross,
  input  wire                        tdr_rx_cross,
  input  wire                        tdr_tx_above5,
  input  wire                        tdr_rx_above5,
  // status
  output reg                         results_valid_ff,
  output reg                         irq_ff
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [`CDAR_AMP_W-1:0]   tx_amp5_ff;
  reg  [`CDAR_PEAKS-1:0]   tx_pol_ff;
  reg  [`CDAR_PEAKS-1:0]   rx_pol_ff;
  reg                      tx_cross_ff;
  reg                      rx_cross_ff;
  reg                      tx_above_ff;
  reg                      rx_above_ff;
  reg                      busy_ff;
  reg  [`CDAR_IRQ_W-1:0]   irq_stat_ff;
  reg  [`CDAR_IRQ_W-1:0]   irq_mask_ff;
  wire [`CDAR_PEAKS*`CDAR_AMP_W-1:0] rx_amp_q;
  wire                     load_res;
  wire                     clr_res;
  wire [`CDAR_IRQ_W-1:0]   irq_evt;
  wire [`CDAR_IRQ_W-1:0]   irq_w1c;
  wire [`CDAR_IRQ_W-1:0]   nxt_irq_stat;
  reg  [`CDAR_DATA_W-1:0]  nxt_rdata;

  // ----------------------------------------------------------------
  // run sequencing
  // ----------------------------------------------------------------
  // a completing run beats a start seen in the same cycle
  assign load_res = tdr_run_done;
  assign clr_res  = tdr_run_start & ~tdr_run_done;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_ff <= 1'b0;
    end
    else if (load_res)
    begin
      busy_ff <= 1'b0;
    end
    else if (clr_res)
    begin
      busy_ff <= 1'b1;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      results_valid_ff <= 1'b0;
    end
    else if (load_res)
    begin
      results_valid_ff <= 1'b1;
    end
    else if (clr_res)
    begin
      results_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive-pair amplitude capture, one entry per peak
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CDAR_PEAKS; gi = gi + 1)
    begin : g_rx
      reg [`CDAR_AMP_W-1:0] amp_ff;
      always @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          amp_ff <= `CDAR_AMP_RST;
        end
        else if (load_res)
        begin
          amp_ff <= tdr_rx_amp[gi*`CDAR_AMP_W +: `CDAR_AMP_W];
        end
        else if (clr_res)
        begin
          amp_ff <= `CDAR_AMP_RST;
        end
      end
      assign rx_amp_q[gi*`CDAR_AMP_W +: `CDAR_AMP_W] = amp_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // transmit amplitude, polarity and flag capture
  // ----------------------------------------------------------------
  // joint result load
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tx_amp5_ff  <= `CDAR_AMP_RST;
      tx_pol_ff   <= `CDAR_POL_RST;
      rx_pol_ff   <= `CDAR_POL_RST;
      tx_cross_ff <= 1'b0;
      rx_cross_ff <= 1'b0;
      tx_above_ff <= 1'b0;
      rx_above_ff <= 1'b0;
    end
    else if (load_res)
    begin
      tx_amp5_ff  <= tdr_tx_amp5;
      tx_pol_ff   <= tdr_tx_pol;
      rx_pol_ff   <= tdr_rx_pol;
      tx_cross_ff <= tdr_tx_cross;
      rx_cross_ff <= tdr_rx_cross;
      tx_above_ff <= tdr_tx_above5;
      rx_above_ff <= tdr_rx_above5;
    end
    else if (clr_res)
    begin
      tx_amp5_ff  <= `CDAR_AMP_RST;
      tx_pol_ff   <= `CDAR_POL_RST;
      rx_pol_ff   <= `CDAR_POL_RST;
      tx_cross_ff <= 1'b0;
      rx_cross_ff <= 1'b0;
      tx_above_ff <= 1'b0;
      rx_above_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign irq_evt[`CDAR_IRQ_DONE]  = load_res;
  assign irq_evt[`CDAR_IRQ_SHORT] = load_res & (tdr_tx_cross | tdr_rx_cross);
  assign irq_evt[`CDAR_IRQ_OVFL]  = load_res & (tdr_tx_above5 | tdr_rx_above5);

  assign irq_w1c = (reg_wr && (reg_addr == `CDAR_OFF_IRQ_STAT)) ?
                   reg_wdata[`CDAR_IRQ_W-1:0] : `CDAR_IRQ_RST;

  // new events win over a clear in the same cycle
  assign nxt_irq_stat = (irq_stat_ff & ~irq_w1c) | irq_evt;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= `CDAR_IRQ_RST;
      irq_mask_ff <= `CDAR_IRQ_RST;
      irq_ff      <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (reg_wr && (reg_addr == `CDAR_OFF_IRQ_MASK))
      begin
        irq_mask_ff <= reg_wdata[`CDAR_IRQ_W-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // read decode; result registers ignore every write
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_rdata = `CDAR_DATA_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        `CDAR_OFF_AMP3:
          nxt_rdata = {1'b0, rx_amp_q[0*`CDAR_AMP_W +: `CDAR_AMP_W],
                       1'b0, tx_amp5_ff};
        `CDAR_OFF_AMP4:
          nxt_rdata = {1'b0, rx_amp_q[2*`CDAR_AMP_W +: `CDAR_AMP_W],
                       1'b0, rx_amp_q[1*`CDAR_AMP_W +: `CDAR_AMP_W]};
        `CDAR_OFF_AMP5:
          nxt_rdata = {1'b0, rx_amp_q[4*`CDAR_AMP_W +: `CDAR_AMP_W],
                       1'b0, rx_amp_q[3*`CDAR_AMP_W +: `CDAR_AMP_W]};
        `CDAR_OFF_GEN:
          nxt_rdata = {tx_pol_ff, rx_pol_ff, tx_cross_ff, rx_cross_ff,
                       tx_above_ff, rx_above_ff, `CDAR_GEN_RSVD};
        `CDAR_OFF_IRQ_STAT:
          nxt_rdata = {{`CDAR_IRQ_PAD_W{1'b0}}, irq_stat_ff};
        `CDAR_OFF_IRQ_MASK:
          nxt_rdata = {{`CDAR_IRQ_PAD_W{1'b0}}, irq_mask_ff};
        `CDAR_OFF_INFO:
          nxt_rdata = {{`CDAR_INFO_PAD_W{1'b0}}, busy_ff, results_valid_ff};
        default:
          nxt_rdata = `CDAR_DATA_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_ff <= `CDAR_DATA_ZERO;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule // cdar_results

// File: verification/cdar_results_properties.sv
// port assertions for the result register bank
module cdar_results_chk (
  // clock and reset
  input logic        ref_clk,
  input logic        sys_rst,
  // register port
  input logic [15:0] reg_addr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata_ff,
  // engine side
  input logic        tdr_run_start,
  input logic        tdr_run_done,
  input logic [6:0]  tdr_tx_amp5,
  input logic [34:0] tdr_rx_amp,
  input logic [4:0]  tdr_tx_pol,
  input logic [4:0]  tdr_rx_pol,
  input logic        tdr_tx_cross,
  input logic        tdr_rx_cross,
  input logic        tdr_tx_above5,
  input logic        tdr_rx_above5,
  input logic        results_valid_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata_ff == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  property p_amp_rsvd;
    $past(reg_rd) && $past(reg_addr) inside {16'h0187, 16'h0188, 16'h0189} |-> !reg_rdata_ff[15] && !reg_rdata_ff[7];
  endproperty
  a_amp_rsvd: assert property (p_amp_rsvd) else $error("amplitude reserved bit set");
  property p_gen_rsvd;
    $past(reg_rd) && $past(reg_addr) == 16'h018A |-> reg_rdata_ff[1:0] == 2'h0;
  endproperty
  a_gen_rsvd: assert property (p_gen_rsvd) else $error("general reserved bits set");
  property p_amp3;
    tdr_run_done ##1 (reg_rd && reg_addr == 16'h0187)
      |=> reg_rdata_ff == {1'b0, $past(tdr_rx_amp[6:0], 2), 1'b0, $past(tdr_tx_amp5, 2)};
  endproperty
  a_amp3: assert property (p_amp3) else $error("amplitude word 3 wrong");
  property p_gen;
    tdr_run_done ##1 (reg_rd && reg_addr == 16'h018A) |=> reg_rdata_ff == {$past(tdr_tx_pol, 2),
      $past(tdr_rx_pol, 2), $past(tdr_tx_cross, 2), $past(tdr_rx_cross, 2), $past(tdr_tx_above5, 2),
      $past(tdr_rx_above5, 2), 2'h0};
  endproperty
  a_gen: assert property (p_gen) else $error("general word wrong");
  property p_valid;
    tdr_run_done |=> results_valid_ff;
  endproperty
  a_valid: assert property (p_valid) else $error("valid missing after done");
  property p_start;
    tdr_run_start && !tdr_run_done |=> !results_valid_ff;
  endproperty
  a_start: assert property (p_start) else $error("valid kept after start");
  property p_hold;
    results_valid_ff && !tdr_run_start |=> results_valid_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("valid dropped without start");
endmodule // cdar_results_chk

bind cdar_results cdar_results_chk chk_u (.ref_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata_ff,
  .tdr_run_start, .tdr_run_done, .tdr_tx_amp5, .tdr_rx_amp, .tdr_tx_pol, .tdr_rx_pol, .tdr_tx_cross,
  .tdr_rx_cross, .tdr_tx_above5, .tdr_rx_above5, .results_valid_ff);

// File: verification/testbench.sv
// self-checking bench for the result register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0;
  logic        sys_rst = 1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic        tdr_run_start = 0;
  logic        tdr_run_done = 0;
  logic [6:0]  tx5 = 7'h00;
  logic [34:0] rxa = 35'h0;
  logic [4:0]  txp = 5'h00;
  logic [4:0]  rxp = 5'h00;
  logic [3:0]  flg = 4'h0;
  wire  [15:0] rdata;
  wire         valid;
  wire         irq;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [15:0] exp_w [4] = '{4{16'h0000}};

  cdar_results dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .tdr_run_start(tdr_run_start),
    .tdr_run_done(tdr_run_done), .tdr_tx_amp5(tx5), .tdr_rx_amp(rxa), .tdr_tx_pol(txp), .tdr_rx_pol(rxp),
    .tdr_tx_cross(flg[3]), .tdr_rx_cross(flg[2]), .tdr_tx_above5(flg[1]), .tdr_rx_above5(flg[0]),
    .results_valid_ff(valid), .irq_ff(irq));

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 4; i++)
      rd(16'(16'h0187 + i), exp_w[i]);
  endtask
  task automatic run(input logic [6:0] t, input logic [34:0] r, input logic [4:0] tp, input logic [4:0] rp,
                     input logic [3:0] f, input logic [15:0] ra);
    exp_w = '{{1'b0, r[6:0], 1'b0, t}, {1'b0, r[20:14], 1'b0, r[13:7]}, {1'b0, r[34:28], 1'b0, r[27:21]},
              {tp, rp, f, 2'h0}};
    @(posedge ref_clk);
    tdr_run_start <= 1'b1;
    @(posedge ref_clk);
    tdr_run_start <= 1'b0;
    tdr_run_done <= 1'b1;
    tx5 <= t;
    rxa <= r;
    txp <= tp;
    rxp <= rp;
    flg <= f;
    @(posedge ref_clk);
    tdr_run_done <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ra;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check("read right after done", rdata, exp_w[2'(ra - 16'h0187)]);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_all();
    rd(16'h01A2, 16'h0000);
    rd(16'h0100, 16'h0000);
    wr(16'h01A1, 16'h0007);
    run(7'h7F, {35{1'b1}}, 5'h1F, 5'h00, 4'hF, 16'h0187);
    rd_all();
    rd(16'h01A2, 16'h0001);
    check("irq", {15'h0, irq}, 16'h0001);
    rd(16'h01A0, 16'h0007);
    wr(16'h01A0, 16'h0007);
    rd(16'h01A0, 16'h0000);
    check("irq", {15'h0, irq}, 16'h0000);
    wr(16'h01A1, 16'h0000);
    run(7'h2A, {7'h55, 7'h33, 7'h4C, 7'h19, 7'h66}, 5'h01, 5'h10, 4'h6, 16'h018A);
    wr(16'h0187, 16'hFFFF);
    wr(16'h018A, 16'hFFFF);
    rd_all();
    rd(16'h01A0, 16'h0007);
    check("irq", {15'h0, irq}, 16'h0000);
    rxa <= 35'h0;
    txp <= 5'h1E;
    flg <= 4'h9;
    rd_all();
    @(posedge ref_clk);
    tdr_run_start <= 1'b1;
    @(posedge ref_clk);
    tdr_run_start <= 1'b0;
    exp_w = '{4{16'h0000}};
    rd_all();
    check("valid", {15'h0, valid}, 16'h0000);
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
endmodule // testbench
